// ---- src/power_exception_control.sv ----
/*
 Power, factory-restore, compatibility, exception and addressing control.
 Assumes the host drives the pins reset_pin_n_i and cmd_n_i asynchronously
 and the control strobes synchronously to mclk_i.
*/
// What this block does
// - Mode 0x03 enters deep sleep, stops radio, oscillator.
// - Deep sleep drives the CTS output high.
// - Wake needs 20us low reset pin, then high.
// - Fully operational under 8 ms after wake release.
// - Check RAM on wake; failure self-resets.
// - Self-reset reloads baud from stored setting.
// - Command pin low 600ms from power-up restores factory.
// - Compatibility mode caps radio rate at 76.8kbps.
// - Errors store code; a read clears it.
// - A new error overwrites the held code.
// - Codes 0x08 UART, 0x09 radio overflow.
// - Code 0x13 on failed register write.
// - Code 0x20 when acknowledgement never arrives.
// - Codes 0x40 payload CRC, 0x42 header CRC.
// - Codes 0x43 bad sequence, 0x44 bad frame.
// - Error line high when code AND mask nonzero.
// - Error line holds until code is read.
// - Mask gates line only, never recording.
// - Net scheme volatile and stored, steers transmit.
// - Receive checks all schemes, forwards matches only.
// - Three schemes: unique id, user, extended user.
// - Reply addressing copies source into destination.
// - Retries beyond limit raise missing acknowledgement.
`timescale 1ns/1ps
`default_nettype none

module power_exception_control #(
   parameter int WAKE_CYCLES = power_exception_pkg::WAKE_TIME_CYCLES,
   parameter int FACTORY_CYCLES = power_exception_pkg::FACTORY_HOLD_CYCLES
) (
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic reset_pin_n_i,
   input wire logic cmd_n_i,
   input wire logic mode_write_i,
   input wire logic [7:0] operating_mode_select_i,
   input wire logic ram_check_ok_i,
   input wire logic baud_write_i,
   input wire logic [2:0] baud_value_i,
   input wire logic stored_baud_write_i,
   input wire logic compat_mode_i,
   input wire logic uart_overflow_i,
   input wire logic radio_overflow_i,
   input wire logic write_fail_i,
   input wire logic payload_crc_bad_i,
   input wire logic header_crc_bad_i,
   input wire logic ack_sequence_bad_i,
   input wire logic frame_kind_bad_i,
   input wire logic ack_enable_i,
   input wire logic tx_attempt_i,
   input wire logic ack_received_i,
   input wire logic retry_limit_write_i,
   input wire logic [3:0] retry_limit_i,
   input wire logic code_read_i,
   input wire logic [7:0] exception_mask_i,
   input wire logic scheme_write_i,
   input wire logic stored_scheme_write_i,
   input wire logic [1:0] scheme_value_i,
   input wire logic live_reply_addressing_i,
   input wire logic stored_reply_addressing_i,
   input wire logic rx_valid_i,
   input wire logic rx_addr_match_i,
   input wire logic [31:0] rx_src_addr_i,
   input wire logic dest_write_i,
   input wire logic [31:0] dest_value_i,
   output logic cts_n_o,
   output logic radio_enable_o,
   output logic osc_enable_o,
   output logic ready_o,
   output logic soft_reset_o,
   output logic factory_restore_o,
   output logic [2:0] volatile_baud_setting_o,
   output logic [2:0] stored_baud_setting_o,
   output logic [11:0] rf_rate_o,
   output logic [7:0] error_code_holder_o,
   output logic error_signal_line_o,
   output logic [3:0] retry_limit_o,
   output logic [1:0] live_net_scheme_o,
   output logic [1:0] stored_net_scheme_o,
   output logic rx_forward_o,
   output logic rx_discard_o,
   output logic [31:0] dest_addr_o
);

   // Four cycles of the wake budget go to the pin synchroniser, release and check.
   if (WAKE_CYCLES < 6 || FACTORY_CYCLES < 2) begin : g_bad_counts
      $error("Wake count must be at least six, factory count at least two.");
   end

   typedef enum logic [2:0] {
      ST_RUN,
      ST_DEEP,
      ST_PIN_LOW,
      ST_WAKING,
      ST_CHECK
   } power_state_t;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers.

   logic rst_pin_meta_reg;
   logic rst_pin_reg;
   logic cmd_meta_reg;
   logic cmd_reg;

   // The command pin synchroniser resets to the held state, so a pin held
   // low through power-up is seen as held from the first cycle.
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         rst_pin_meta_reg <= 1'b1;
         rst_pin_reg <= 1'b1;
         cmd_meta_reg <= 1'b0;
         cmd_reg <= 1'b0;
      end else begin
         rst_pin_meta_reg <= reset_pin_n_i;
         rst_pin_reg <= rst_pin_meta_reg;
         cmd_meta_reg <= cmd_n_i;
         cmd_reg <= cmd_meta_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Deep sleep and wake sequence.

   power_state_t state_reg;
   logic [31:0] count_reg;
   logic soft_reset_reg;

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         state_reg <= ST_RUN;
         count_reg <= 32'h0000_0000;
         soft_reset_reg <= 1'b0;
      end else begin
         soft_reset_reg <= 1'b0;
         case (state_reg)
            ST_RUN: begin
               if (mode_write_i && operating_mode_select_i == power_exception_pkg::MODE_DEEP_SLEEP) begin
                  state_reg <= ST_DEEP;
               end
            end
            ST_DEEP: begin
               count_reg <= 32'h0000_0000;
               if (!rst_pin_reg) begin
                  state_reg <= ST_PIN_LOW;
               end
            end
            ST_PIN_LOW: begin
               // A short pulse is ignored; a long one waits for release.
               if (rst_pin_reg) begin
                  count_reg <= 32'h0000_0000;
                  if (count_reg >= 32'(power_exception_pkg::WAKE_PULSE_CYCLES - 1)) begin
                     state_reg <= ST_WAKING;
                  end else begin
                     state_reg <= ST_DEEP;
                  end
               end else if (count_reg < 32'(power_exception_pkg::WAKE_PULSE_CYCLES)) begin
                  count_reg <= count_reg + 32'h0000_0001;
               end
            end
            ST_WAKING: begin
               count_reg <= count_reg + 32'h0000_0001;
               if (count_reg >= 32'(WAKE_CYCLES - 5)) begin
                  state_reg <= ST_CHECK;
               end
            end
            default: begin
               // A failed check forces re-initialisation in the same cycle as the return to ST_RUN.
               soft_reset_reg <= !ram_check_ok_i;
               state_reg <= ST_RUN;
            end
         endcase
      end
   end

   logic asleep;
   assign asleep = state_reg != ST_RUN;
   assign cts_n_o = asleep;
   assign radio_enable_o = !asleep;
   assign osc_enable_o = !asleep;
   assign ready_o = !asleep;
   assign soft_reset_o = soft_reset_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Factory restore on a command pin held from power-up.

   logic fac_armed_reg;
   logic [31:0] fac_count_reg;
   logic fac_pulse_reg;

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         fac_armed_reg <= 1'b1;
         fac_count_reg <= 32'h0000_0000;
         fac_pulse_reg <= 1'b0;
      end else begin
         fac_pulse_reg <= 1'b0;
         if (fac_armed_reg) begin
            if (cmd_reg) begin
               fac_armed_reg <= 1'b0;
               fac_pulse_reg <= fac_count_reg >= 32'(FACTORY_CYCLES);
            end else if (fac_count_reg < 32'(FACTORY_CYCLES)) begin
               fac_count_reg <= fac_count_reg + 32'h0000_0001;
            end
         end
      end
   end

   assign factory_restore_o = fac_pulse_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Baud settings and radio rate.

   logic [2:0] vol_baud_reg;
   logic [2:0] nv_baud_reg;
   logic [11:0] rf_rate_reg;

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         vol_baud_reg <= power_exception_pkg::BAUD_FACTORY;
         nv_baud_reg <= power_exception_pkg::BAUD_FACTORY;
      end else begin
         if (fac_pulse_reg) begin
            nv_baud_reg <= power_exception_pkg::BAUD_FACTORY;
            vol_baud_reg <= power_exception_pkg::BAUD_FACTORY;
         end else if (soft_reset_reg) begin
            vol_baud_reg <= nv_baud_reg;
         end else begin
            if (baud_write_i) begin
               vol_baud_reg <= baud_value_i;
            end
            if (stored_baud_write_i) begin
               nv_baud_reg <= baud_value_i;
            end
         end
      end
   end

   // The baud table is untouched; only the radio side is clamped.
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         rf_rate_reg <= power_exception_pkg::RF_NATIVE_RATE[0];
      end else if (compat_mode_i && power_exception_pkg::RF_NATIVE_RATE[vol_baud_reg] >
                   power_exception_pkg::RF_RATE_CAP) begin
         rf_rate_reg <= power_exception_pkg::RF_RATE_CAP;
      end else begin
         rf_rate_reg <= power_exception_pkg::RF_NATIVE_RATE[vol_baud_reg];
      end
   end

   assign volatile_baud_setting_o = vol_baud_reg;
   assign stored_baud_setting_o = nv_baud_reg;
   assign rf_rate_o = rf_rate_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Retry tracking for acknowledged delivery.

   logic [3:0] retry_limit_reg;
   logic [4:0] retry_count_reg;
   logic missing_ack;

   assign missing_ack = ack_enable_i && tx_attempt_i && !ack_received_i &&
                        retry_count_reg >= {1'b0, retry_limit_reg};

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         retry_limit_reg <= power_exception_pkg::RETRY_FACTORY;
         retry_count_reg <= 5'h00;
      end else begin
         if (fac_pulse_reg) begin
            retry_limit_reg <= power_exception_pkg::RETRY_FACTORY;
         end else if (retry_limit_write_i) begin
            retry_limit_reg <= retry_limit_i;
         end
         if (ack_received_i || missing_ack || !ack_enable_i) begin
            retry_count_reg <= 5'h00;
         end else if (tx_attempt_i) begin
            retry_count_reg <= retry_count_reg + 5'h01;
         end
      end
   end

   assign retry_limit_o = retry_limit_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Exception engine.

   logic [7:0] code_reg;
   logic [7:0] code_event;
   logic line_reg;

   // One code per cycle; when several errors coincide the later-listed
   // error wins, as a newer code would overwrite an older one anyway.
   always_comb begin
      code_event = power_exception_pkg::CODE_NONE;
      if (uart_overflow_i) code_event = power_exception_pkg::UART_OVERFLOW_CODE;
      if (radio_overflow_i) code_event = power_exception_pkg::RADIO_OVERFLOW_CODE;
      if (write_fail_i) code_event = power_exception_pkg::WRITE_FAIL_CODE;
      if (missing_ack) code_event = power_exception_pkg::MISSING_ACK_CODE;
      if (payload_crc_bad_i) code_event = power_exception_pkg::PAYLOAD_CRC_CODE;
      if (header_crc_bad_i) code_event = power_exception_pkg::HEADER_CRC_CODE;
      if (ack_sequence_bad_i) code_event = power_exception_pkg::ACK_SEQUENCE_CODE;
      if (frame_kind_bad_i) code_event = power_exception_pkg::FRAME_KIND_CODE;
   end

   // A new error in the read cycle is kept, so nothing is lost.
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         code_reg <= power_exception_pkg::CODE_NONE;
      end else if (code_event != power_exception_pkg::CODE_NONE) begin
         code_reg <= code_event;
      end else if (code_read_i) begin
         code_reg <= power_exception_pkg::CODE_NONE;
      end
   end

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         line_reg <= 1'b0;
      end else begin
         line_reg <= |(code_reg & exception_mask_i);
      end
   end

   assign error_code_holder_o = code_reg;
   assign error_signal_line_o = line_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Network scheme and addressing.

   power_exception_pkg::net_scheme_t live_scheme_reg;
   power_exception_pkg::net_scheme_t nv_scheme_reg;
   power_exception_pkg::net_scheme_t scheme_in;
   logic [31:0] dest_reg;
   logic fwd_reg;
   logic drop_reg;

   // The unused fourth encoding falls back to the unique id scheme.
   assign scheme_in = (scheme_value_i == 2'h3) ? power_exception_pkg::UNIQUE_ID_SCHEME :
                      power_exception_pkg::net_scheme_t'(scheme_value_i);

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         live_scheme_reg <= power_exception_pkg::SCHEME_FACTORY;
         nv_scheme_reg <= power_exception_pkg::SCHEME_FACTORY;
      end else if (fac_pulse_reg) begin
         nv_scheme_reg <= power_exception_pkg::SCHEME_FACTORY;
         live_scheme_reg <= power_exception_pkg::SCHEME_FACTORY;
      end else begin
         if (scheme_write_i) begin
            live_scheme_reg <= scheme_in;
         end
         if (stored_scheme_write_i) begin
            nv_scheme_reg <= scheme_in;
         end
      end
   end

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         dest_reg <= 32'h0000_0000;
      end else if (rx_valid_i && rx_addr_match_i &&
                   (live_reply_addressing_i || stored_reply_addressing_i)) begin
         dest_reg <= rx_src_addr_i;
      end else if (dest_write_i) begin
         dest_reg <= dest_value_i;
      end
   end

   // Matching is done for every scheme regardless of the live one.
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         fwd_reg <= 1'b0;
         drop_reg <= 1'b0;
      end else begin
         fwd_reg <= rx_valid_i && rx_addr_match_i;
         drop_reg <= rx_valid_i && !rx_addr_match_i;
      end
   end

   assign live_net_scheme_o = live_scheme_reg;
   assign stored_net_scheme_o = nv_scheme_reg;
   assign dest_addr_o = dest_reg;
   assign rx_forward_o = fwd_reg;
   assign rx_discard_o = drop_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   sequence s_sleep_cmd;
      state_reg == ST_RUN && mode_write_i && operating_mode_select_i == power_exception_pkg::MODE_DEEP_SLEEP;
   endsequence

   property p_deep_entry;
      @(posedge mclk_i) disable iff (reset_i)
      s_sleep_cmd |=> cts_n_o && !radio_enable_o && !osc_enable_o;
   endproperty
   a_deep_entry: assert property (p_deep_entry) else $error("Deep sleep not entered.");

   property p_cts_high;
      @(posedge mclk_i) disable iff (reset_i)
      state_reg == ST_DEEP |-> cts_n_o;
   endproperty
   a_cts_high: assert property (p_cts_high) else $error("CTS low in deep sleep.");

   property p_no_wake_while_low;
      @(posedge mclk_i) disable iff (reset_i)
      state_reg == ST_PIN_LOW && !rst_pin_reg |=> state_reg == ST_PIN_LOW;
   endproperty
   a_no_wake_while_low: assert property (p_no_wake_while_low) else $error("Wake began while pin low.");

   property p_short_pulse;
      @(posedge mclk_i) disable iff (reset_i)
      $rose(state_reg == ST_PIN_LOW) ##1 (!rst_pin_reg) [*3] ##1 rst_pin_reg |=> state_reg == ST_DEEP;
   endproperty
   a_short_pulse: assert property (p_short_pulse) else $error("Short pulse woke the device.");

   property p_wake_time;
      @(posedge mclk_i) disable iff (reset_i)
      state_reg == ST_WAKING && count_reg == 32'(WAKE_CYCLES - 5) |=> state_reg == ST_CHECK ##1 ready_o;
   endproperty
   a_wake_time: assert property (p_wake_time) else $error("Wake took too long.");

   property p_ram_fail;
      @(posedge mclk_i) disable iff (reset_i)
      state_reg == ST_CHECK && !ram_check_ok_i |=> soft_reset_o ##1 volatile_baud_setting_o == $past(stored_baud_setting_o);
   endproperty
   a_ram_fail: assert property (p_ram_fail) else $error("Failed check did not reload.");

   property p_read_clears;
      @(posedge mclk_i) disable iff (reset_i)
      code_read_i && code_event == power_exception_pkg::CODE_NONE |=> error_code_holder_o == power_exception_pkg::CODE_NONE;
   endproperty
   a_read_clears: assert property (p_read_clears) else $error("Read did not clear code.");

   property p_overwrite;
      @(posedge mclk_i) disable iff (reset_i)
      write_fail_i && !missing_ack && !payload_crc_bad_i && !header_crc_bad_i && !ack_sequence_bad_i &&
      !frame_kind_bad_i |=> error_code_holder_o == power_exception_pkg::WRITE_FAIL_CODE;
   endproperty
   a_overwrite: assert property (p_overwrite) else $error("Write fail code not held.");

   property p_line;
      @(posedge mclk_i) disable iff (reset_i)
      ##1 error_signal_line_o == |($past(error_code_holder_o) & $past(exception_mask_i));
   endproperty
   a_line: assert property (p_line) else $error("Error line mismatch.");

   property p_line_until_read;
      @(posedge mclk_i) disable iff (reset_i)
      code_read_i && code_event == power_exception_pkg::CODE_NONE |-> ##2 !error_signal_line_o;
   endproperty
   a_line_until_read: assert property (p_line_until_read) else $error("Line stayed after read.");

   property p_reply_addr;
      @(posedge mclk_i) disable iff (reset_i)
      rx_valid_i && rx_addr_match_i && (live_reply_addressing_i || stored_reply_addressing_i)
      |=> dest_addr_o == $past(rx_src_addr_i) && rx_forward_o;
   endproperty
   a_reply_addr: assert property (p_reply_addr) else $error("Destination not copied.");

   property p_missing_ack;
      @(posedge mclk_i) disable iff (reset_i)
      missing_ack && !payload_crc_bad_i && !header_crc_bad_i && !ack_sequence_bad_i && !frame_kind_bad_i
      |=> error_code_holder_o == power_exception_pkg::MISSING_ACK_CODE;
   endproperty
   a_missing_ack: assert property (p_missing_ack) else $error("Missing acknowledgement not raised.");

endmodule // power_exception_control

`default_nettype wire

// ---- src/power_exception_pkg.sv ----
/*
 Constants shared by the power and exception control block: pin timing,
 operating mode values, error codes, baud and radio rate tables.
 Assumes a 25 MHz protocol clock; all cycle counts derive from it.
*/
package power_exception_pkg;

   localparam int CLK_PERIOD_NS = 40;

   // Wake pulse is a least time, so it rounds up.
   localparam int WAKE_PULSE_NS = 20000;
   localparam int WAKE_PULSE_CYCLES = (WAKE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Wake-up time is a longest time, so it rounds down.
   localparam int WAKE_TIME_NS = 8000000;
   localparam int WAKE_TIME_CYCLES = WAKE_TIME_NS / CLK_PERIOD_NS;
   localparam int FACTORY_HOLD_NS = 600000000;
   localparam int FACTORY_HOLD_CYCLES = (FACTORY_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   localparam logic [7:0] MODE_DEEP_SLEEP = 8'h03;

   localparam logic [7:0] CODE_NONE = 8'h00;
   localparam logic [7:0] UART_OVERFLOW_CODE = 8'h08;
   localparam logic [7:0] RADIO_OVERFLOW_CODE = 8'h09;
   localparam logic [7:0] WRITE_FAIL_CODE = 8'h13;
   localparam logic [7:0] MISSING_ACK_CODE = 8'h20;
   localparam logic [7:0] PAYLOAD_CRC_CODE = 8'h40;
   localparam logic [7:0] HEADER_CRC_CODE = 8'h42;
   localparam logic [7:0] ACK_SEQUENCE_CODE = 8'h43;
   localparam logic [7:0] FRAME_KIND_CODE = 8'h44;

   localparam logic [2:0] BAUD_FACTORY = 3'h0;
   localparam logic [3:0] RETRY_FACTORY = 4'h3;

   // Radio rates in tenths of a kbps, indexed by baud setting.
   localparam logic [11:0] RF_RATE_CAP = 12'h300;
   localparam logic [11:0] RF_NATIVE_RATE [8] = '{12'h060, 12'h0c0, 12'h180, 12'h300,
                                                  12'h300, 12'h600, 12'h600, 12'h600};

   typedef enum logic [1:0] {
      UNIQUE_ID_SCHEME,
      USER_SCHEME,
      EXTENDED_USER_SCHEME
   } net_scheme_t;

   localparam net_scheme_t SCHEME_FACTORY = UNIQUE_ID_SCHEME;

endpackage

// ---- sim/host_pins.sv ----
/*
 Host model for the wake and command control pins.
 Assumes the bench supplies the design clock; pins idle high like pull-ups.
*/
`timescale 1ns/1ps
`default_nettype none
module host_pins (
   input wire logic mclk_i,
   output logic reset_pin_n_o,
   output logic cmd_n_o
);
   initial begin
      reset_pin_n_o = 1'b1;
      cmd_n_o = 1'b1;
   end
   // Waking starts on the rise, so the low time alone must not wake it.
   task automatic pin_low(input int n);
      @(negedge mclk_i) reset_pin_n_o = 1'b0;
      repeat (n) @(negedge mclk_i);
      reset_pin_n_o = 1'b1;
   endtask
   task automatic cmd_set(input logic v);
      @(negedge mclk_i) cmd_n_o = v;
   endtask
endmodule // host_pins
`default_nettype wire

// ---- sim/testbench.sv ----
/*
 Self-checking bench for power_exception_control with shortened counts.
 Assumes host_pins drives the pins; all other inputs change on falling edges.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam int WK = 20;
   localparam int FC = 30;
   logic mclk_i = 1'b0, reset_i = 1'b1, mode_write_i = 1'b0, ram_check_ok_i = 1'b1;
   logic baud_write_i = 1'b0, stored_baud_write_i = 1'b0, compat_mode_i = 1'b0, ack_enable_i = 1'b0;
   logic tx_attempt_i = 1'b0, ack_received_i = 1'b0, retry_limit_write_i = 1'b0, code_read_i = 1'b0;
   logic scheme_write_i = 1'b0, stored_scheme_write_i = 1'b0, live_reply_addressing_i = 1'b0;
   logic stored_reply_addressing_i = 1'b0, rx_valid_i = 1'b0, rx_addr_match_i = 1'b0, dest_write_i = 1'b0;
   logic [7:0] operating_mode_select_i = 8'h00, exception_mask_i = 8'hff;
   logic [6:0] err = 7'h00;
   logic [2:0] baud_value_i = 3'h0;
   logic [3:0] retry_limit_i = 4'h0;
   logic [1:0] scheme_value_i = 2'h0;
   logic [31:0] rx_src_addr_i = 32'h0, dest_value_i = 32'h0;
   wire logic reset_pin_n_i, cmd_n_i;
   logic cts_n_o, radio_enable_o, osc_enable_o, ready_o, soft_reset_o, factory_restore_o;
   logic error_signal_line_o, rx_forward_o, rx_discard_o;
   logic [2:0] volatile_baud_setting_o, stored_baud_setting_o;
   logic [11:0] rf_rate_o;
   logic [7:0] error_code_holder_o;
   logic [3:0] retry_limit_o;
   logic [1:0] live_net_scheme_o, stored_net_scheme_o;
   logic [31:0] dest_addr_o;
   logic [7:0] codes [7] = '{8'h08, 8'h09, 8'h13, 8'h40, 8'h42, 8'h43, 8'h44};
   int fails = 0, checks_done = 0, cyc = 0;
   power_exception_control #(.WAKE_CYCLES(WK), .FACTORY_CYCLES(FC)) power_exception_control_inst (.*,
      .uart_overflow_i(err[0]), .radio_overflow_i(err[1]), .write_fail_i(err[2]),
      .payload_crc_bad_i(err[3]), .header_crc_bad_i(err[4]), .ack_sequence_bad_i(err[5]),
      .frame_kind_bad_i(err[6]));
   host_pins host_pins_inst (.mclk_i(mclk_i), .reset_pin_n_o(reset_pin_n_i), .cmd_n_o(cmd_n_i));
   ////////////////////////////////////////////////////////////////////////////////
   initial forever #20 mclk_i = ~mclk_i;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t %s got %0h exp %0h", $time, what, got, exp);
      end
   endtask
   task automatic cw(input int n);
      repeat (n) @(negedge mclk_i);
   endtask
   task automatic hit(ref logic s);
      @(negedge mclk_i) s = 1'b1;
      @(negedge mclk_i) s = 1'b0;
   endtask
   task automatic summarize;
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // The run needs under 2000 cycles; a hang is cut at 5000.
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc > 5000) begin
         fails++;
         summarize();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [7:0] m;
      logic [7:0] q [$];
      logic [11:0] r;
      logic [31:0] a;
      logic [2:0] sb;
      void'($urandom(32'h1da4a178));
      cw(4);
      reset_i = 1'b0;
      cw(1);
      chk(error_signal_line_o, 0, "line idle");
      for (int i = 0; i < 7; i++) begin
         m = 8'($urandom);
         exception_mask_i = m;
         err[i] = 1'b1;
         q.push_back(codes[i]);
         cw(1);
         err = 7'h00;
         cw(3);
         chk(error_code_holder_o, q[$], "code");
         chk(error_signal_line_o, |(q[$] & m), "line");
         hit(code_read_i);
         cw(3);
         chk(error_code_holder_o, 0, "clear");
         chk(error_signal_line_o, 0, "line clr");
      end
      exception_mask_i = 8'hff;
      err = 7'h02;
      cw(1);
      err = 7'h41;
      cw(1);
      err = 7'h00;
      cw(20);
      chk(error_code_holder_o, 8'h44, "overwrite");
      chk(error_signal_line_o, 1, "held");
      hit(code_read_i);
      ack_enable_i = 1'b1;
      retry_limit_i = 4'h1;
      hit(retry_limit_write_i);
      chk(retry_limit_o, 1, "limit");
      hit(tx_attempt_i);
      cw(3);
      chk(error_code_holder_o, 0, "early ack");
      hit(tx_attempt_i);
      cw(3);
      chk(error_code_holder_o, 8'h20, "no ack");
      hit(code_read_i);
      for (int b = 0; b < 8; b++) begin
         compat_mode_i = 1'($urandom);
         baud_value_i = 3'(b);
         hit(baud_write_i);
         cw(2);
         r = power_exception_pkg::RF_NATIVE_RATE[b];
         if (compat_mode_i && r > 12'h300) r = 12'h300;
         chk(rf_rate_o, r, "rate");
      end
      for (int s = 0; s < 4; s++) begin
         scheme_value_i = 2'(s);
         hit(scheme_write_i);
         cw(1);
         chk(live_net_scheme_o, (s == 3) ? 0 : s, "scheme");
      end
      a = $urandom;
      rx_src_addr_i = a;
      stored_reply_addressing_i = 1'b1;
      rx_addr_match_i = 1'b1;
      hit(rx_valid_i);
      chk(rx_forward_o, 1, "fwd");
      rx_addr_match_i = 1'b0;
      rx_src_addr_i = ~a;
      hit(rx_valid_i);
      chk(rx_discard_o, 1, "drop");
      cw(2);
      chk(dest_addr_o, a, "reply addr");
      dest_value_i = ~a;
      hit(dest_write_i);
      chk(dest_addr_o, ~a, "dest write");
      sb = 3'($urandom);
      baud_value_i = sb;
      hit(stored_baud_write_i);
      baud_value_i = ~sb;
      hit(baud_write_i);
      operating_mode_select_i = 8'h03;
      hit(mode_write_i);
      cw(2);
      chk(cts_n_o, 1, "cts");
      chk(radio_enable_o | osc_enable_o, 0, "stop");
      host_pins_inst.pin_low(5);
      cw(WK + 20);
      chk(cts_n_o, 1, "short pulse");
      ram_check_ok_i = 1'b0;
      host_pins_inst.pin_low(520);
      chk(ready_o, 0, "before rise");
      for (int n = 0; n < WK && ready_o !== 1'b1; n++) cw(1);
      chk(ready_o, 1, "woke");
      chk(soft_reset_o, 1, "self reset");
      cw(3);
      chk(volatile_baud_setting_o, sb, "reload");
      host_pins_inst.cmd_set(1'b0);
      reset_i = 1'b1;
      cw(4);
      reset_i = 1'b0;
      baud_value_i = 3'h6;
      hit(stored_baud_write_i);
      retry_limit_i = 4'h7;
      hit(retry_limit_write_i);
      scheme_value_i = 2'h2;
      hit(stored_scheme_write_i);
      cw(FC + 10);
      chk(stored_baud_setting_o, 6, "pre");
      chk(stored_net_scheme_o, 2, "stored scheme");
      chk(retry_limit_o, 7, "pre limit");
      host_pins_inst.cmd_set(1'b1);
      cw(3);
      chk(factory_restore_o, 1, "restore pulse");
      cw(3);
      chk(stored_baud_setting_o, 0, "factory");
      chk(stored_net_scheme_o, 0, "factory scheme");
      chk(retry_limit_o, 3, "factory limit");
      summarize();
   end
endmodule // testbench
`default_nettype wire
